// File: src/token_host_regs.svh
// Purpose: Constants for the token semaphore host controller
// Assumes: 25 MHz clk, one port of a two-port token semaphore device
// Notes:   Pin timing is counted in whole clk cycles
`ifndef TOKEN_HOST_REGS_SVH
`define TOKEN_HOST_REGS_SVH
`define TOKEN_COUNT       8
`define TOKEN_IDX_W       3
`define TOKEN_ADDR_W      15
`define TOKEN_DATA_W      8
`define TOKEN_FREE_BIT    1'b1
`define TOKEN_TAKE_BIT    1'b0
`define CLK_PERIOD_NS     40
`define STROBE_TIME_NS    80
`define STROBE_CYCLES     ((`STROBE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_TIME_NS       40
`define GAP_CYCLES        ((`GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W             4
`define CNT_ZERO          4'h0
`endif

// File: src/token_host_pkg.sv
// Purpose: Types for the token semaphore host controller
// Assumes: Included constants header
// Notes:   Commands of the user port
package token_host_pkg;
  typedef enum logic [1:0] {
    cmd_take,
    cmd_release,
    cmd_poll,
    cmd_init_all
  } cmd_t;
endpackage

// File: src/token_strobe_timer.sv
// Purpose: Cycle timer that paces strobe phases
// Assumes: Same clock as the controller
// Notes:   busy stays high while the count is nonzero after a load
`include "token_host_regs.svh"
module token_strobe_timer #(
  parameter int CNT_W = `CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  busy
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != {CNT_W{1'b0}}) begin
      cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != {CNT_W{1'b0}});
endmodule

// File: src/token_host_ctrl.sv
// Purpose: Host side controller that claims and releases tokens on one port
// Assumes: Device pins are asynchronous; read data is synchronised here
// Notes:   One command at a time; take is write zero then read back
`include "token_host_regs.svh"
module token_host_ctrl
  import token_host_pkg::*;
#(
  parameter int STROBE_CYC = `STROBE_CYCLES,
  parameter int GAP_CYC    = `GAP_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      cmd_valid,
  input  wire token_host_pkg::cmd_t      cmd,
  input  wire logic [`TOKEN_IDX_W-1:0]   cmd_index,
  output logic                           cmd_ready,
  output logic                           done,
  output logic                           granted,
  output logic                           mem_enable_n,
  output logic                           token_space_select_n,
  output logic                           out_enable_n,
  output logic                           write_n,
  output logic [`TOKEN_ADDR_W-1:0]       addr,
  output logic [`TOKEN_DATA_W-1:0]       data_out,
  output logic                           data_oe,
  input  wire logic [`TOKEN_DATA_W-1:0]  data_in
);
  typedef enum logic [2:0] {st_idle, st_wr, st_gap, st_rd, st_end} state_t;

  state_t                  state_reg, state_next;
  cmd_t                    cmd_reg, cmd_next;
  logic [`TOKEN_IDX_W-1:0] idx_reg, idx_next;
  logic                    granted_reg, granted_next;
  logic                    done_reg, done_next;
  logic                    load;
  logic [`CNT_W-1:0]       load_val;
  logic                    busy;
  logic                    d0_meta_reg, d0_sync_reg;

  // Two flops on the device data line before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      d0_meta_reg <= 1'b1;
      d0_sync_reg <= 1'b1;
    end else if (ce) begin
      d0_meta_reg <= data_in[0];
      d0_sync_reg <= d0_meta_reg;
    end
  end

  token_strobe_timer #(.CNT_W(`CNT_W)) u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (load),
    .load_val (load_val),
    .busy     (busy)
  );

  always_comb begin
    state_next   = state_reg;
    cmd_next     = cmd_reg;
    idx_next     = idx_reg;
    granted_next = granted_reg;
    done_next    = 1'b0;
    load         = 1'b0;
    load_val     = `CNT_ZERO;
    unique case (state_reg)
      st_idle: begin
        if (cmd_valid) begin
          cmd_next = cmd;
          idx_next = (cmd == cmd_init_all) ? '0 : cmd_index;
          load     = 1'b1;
          load_val = `CNT_W'(STROBE_CYC);
          // Take and release both begin with a write; never read first
          state_next = (cmd == cmd_poll) ? st_rd : st_wr;
        end
      end
      st_wr: begin
        if (!busy) begin
          load     = 1'b1;
          load_val = `CNT_W'(GAP_CYC);
          state_next = st_gap;
        end
      end
      st_gap: begin
        // Strobes off between accesses so the device relatches the flag
        if (!busy) begin
          load     = 1'b1;
          load_val = `CNT_W'(STROBE_CYC);
          if (cmd_reg == cmd_take || cmd_reg == cmd_poll) begin
            state_next = st_rd;
          end else if (cmd_reg == cmd_init_all &&
                       idx_reg != `TOKEN_IDX_W'(`TOKEN_COUNT - 1)) begin
            idx_next   = idx_reg + `TOKEN_IDX_W'(1);
            state_next = st_wr;
          end else begin
            state_next = st_end;
          end
        end
      end
      st_rd: begin
        // Synchroniser delay fits inside the strobe length
        if (!busy) begin
          granted_next = (d0_sync_reg == `TOKEN_TAKE_BIT);
          load         = 1'b1;
          load_val     = `CNT_W'(GAP_CYC);
          state_next   = st_gap;
          cmd_next     = cmd_release;
          if (cmd_reg == cmd_poll || cmd_reg == cmd_take) begin
            cmd_next = cmd_poll;
          end
        end
      end
      st_end: begin
        done_next  = 1'b1;
        state_next = st_idle;
      end
    endcase
    // After read, gap leads to end for poll and take
    if (state_reg == st_gap && !busy && cmd_reg == cmd_poll && state_next == st_rd) begin
      state_next = st_end;
      load       = 1'b0;
    end
    if (state_reg == st_idle && cmd_valid && cmd == cmd_release) begin
      granted_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg   <= st_idle;
      cmd_reg     <= cmd_take;
      idx_reg     <= '0;
      granted_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else if (ce) begin
      state_reg   <= state_next;
      cmd_reg     <= cmd_next;
      idx_reg     <= idx_next;
      granted_reg <= granted_next;
      done_reg    <= done_next;
    end
  end

  // Pin drive: memory enable always high, token space only when accessing
  assign mem_enable_n         = 1'b1;
  assign token_space_select_n = !(state_reg == st_wr || state_reg == st_rd);
  assign out_enable_n         = (state_reg != st_rd);
  assign write_n              = (state_reg != st_wr);
  assign data_oe              = (state_reg == st_wr);
  assign addr     = {{(`TOKEN_ADDR_W-`TOKEN_IDX_W){1'b0}}, idx_reg};
  // Release and init write one, take writes zero on bit zero
  assign data_out = {`TOKEN_DATA_W{(cmd_reg == cmd_take) ? `TOKEN_TAKE_BIT
                                                         : `TOKEN_FREE_BIT}};
  assign cmd_ready = (state_reg == st_idle);
  assign done      = done_reg;
  assign granted   = granted_reg;

  a_select_enable: assert property (@(posedge clk) disable iff (!rst_n)
    !token_space_select_n |-> mem_enable_n)
    else $error("token access with memory enable low");
  a_read_gap: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(out_enable_n) && ce) |-> $past(token_space_select_n))
    else $error("read strobe without gap");
  a_write_first: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == st_idle && cmd_valid && ce && cmd == cmd_take) |=> !write_n)
    else $error("take did not start with write");
  a_take_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (!write_n && cmd_reg == cmd_take) |-> data_out[0] == 1'b0)
    else $error("take wrote a one");
  a_release_one: assert property (@(posedge clk) disable iff (!rst_n)
    (!write_n && cmd_reg != cmd_take) |-> data_out[0] == 1'b1)
    else $error("release wrote a zero");
  a_addr_range: assert property (@(posedge clk) disable iff (!rst_n)
    addr[`TOKEN_ADDR_W-1:`TOKEN_IDX_W] == '0)
    else $error("high address bits driven");
  c_take: cover property (@(posedge clk) disable iff (!rst_n) done && granted);
  c_fail: cover property (@(posedge clk) disable iff (!rst_n) done && !granted);
  c_init: cover property (@(posedge clk) disable iff (!rst_n)
    cmd_reg == cmd_init_all && idx_reg == `TOKEN_IDX_W'(`TOKEN_COUNT - 1) && !write_n);
endmodule

// File: verification/token_device_model.sv
// Purpose: Two-port token semaphore device model; left port faces the host controller
// Assumes: Sampled on the falling clk edge, away from the edge that launches the strobes
// Notes:   Released data lines show the inverse of the last value, never a stale match
module token_device_model (
  input  wire logic        clk, l_ce_n, l_sel_n, l_oe_n, l_we_n,
  input  wire logic [14:0] l_addr,
  input  wire logic [7:0]  l_din,
  output logic      [7:0]  l_dout,
  input  wire logic        r_sel_n, r_oe_n, r_we_n, r_din,
  input  wire logic [2:0]  r_idx,
  output logic      [7:0]  r_dout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] req_l = 8'hxx;
  logic [7:0] req_r = 8'hxx;
  logic [1:0] own [8] = '{default: 2'h0};
  logic       l_act, l_act_q = 1'b0, lq = 1'b1, r_act, r_act_q = 1'b0, rq = 1'b1;
  logic [2:0] li;
  assign li = l_addr[2:0];
  // Falling edge stands in for the asynchronous access, so read data is settled by the next rise
  always @(negedge clk) begin
    if (l_ce_n && !l_sel_n && !l_we_n) req_l[li] = l_din[0];
    if (!r_sel_n && !r_we_n) req_r[r_idx] = r_din;
    for (int i = 0; i < 8; i++) begin
      if (own[i] == 2'h1 && req_l[i] !== 1'b0) own[i] = 2'h0;
      if (own[i] == 2'h2 && req_r[i] !== 1'b0) own[i] = 2'h0;
      // Left wins exact ties so runs repeat
      if (own[i] == 2'h0 && req_l[i] === 1'b0) own[i] = 2'h1;
      else if (own[i] == 2'h0 && req_r[i] === 1'b0) own[i] = 2'h2;
    end
    l_act = l_ce_n && !l_sel_n && !l_oe_n;
    r_act = !r_sel_n && !r_oe_n;
    if (l_act && !l_act_q) lq = (own[li] != 2'h1);
    if (r_act && !r_act_q) rq = (own[r_idx] != 2'h2);
    l_act_q = l_act;
    r_act_q = r_act;
  end
  assign l_dout = l_act_q ? {8{lq}} : {8{!lq}};
  assign r_dout = r_act_q ? {8{rq}} : {8{!rq}};
endmodule

// File: verification/dual_port_semaphore_flags_tb.sv
// Purpose: Self-checking bench for the token host controller
// Assumes: Device model on the far side, bench plays the other processor
// Notes:   ce is dropped once to show that a request is not taken while frozen
`include "token_host_regs.svh"
module dual_port_semaphore_flags_tb;
  import token_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {cmd_t c; logic [2:0] i; logic g;} row_t;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cmd_valid = 1'b0, cmd_ready, done, granted;
  logic mem_enable_n, sel_n, oe_n, we_n, data_oe;
  logic r_sel_n = 1'b1, r_oe_n = 1'b1, r_we_n = 1'b1, r_din = 1'b1;
  logic [2:0] r_idx = 3'h0, cmd_index = 3'h0;
  logic [14:0] addr;
  logic [7:0] data_out, data_in, r_dout, d;
  cmd_t cmd = cmd_poll;
  int err_count = 0, n_tests = 0, lat;
  row_t rows [6] = '{'{cmd_take, 3'h0, 1'b1}, '{cmd_take, 3'h7, 1'b1},
    '{cmd_poll, 3'h0, 1'b1}, '{cmd_release, 3'h0, 1'b0},
    '{cmd_poll, 3'h0, 1'b0}, '{cmd_release, 3'h7, 1'b0}};
  token_host_ctrl uut (.clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_index(cmd_index), .cmd_ready(cmd_ready), .done(done), .granted(granted),
    .mem_enable_n(mem_enable_n), .token_space_select_n(sel_n), .out_enable_n(oe_n),
    .write_n(we_n), .addr(addr), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  token_device_model dev (.clk(clk), .l_ce_n(mem_enable_n), .l_sel_n(sel_n), .l_oe_n(oe_n),
    .l_we_n(we_n), .l_addr(addr), .l_din(data_out), .l_dout(data_in), .r_sel_n(r_sel_n),
    .r_oe_n(r_oe_n), .r_we_n(r_we_n), .r_din(r_din), .r_idx(r_idx), .r_dout(r_dout));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Host command; for take and release the index driven on the write strobe is checked too
  task automatic run(input cmd_t c, input logic [2:0] i);
    logic [14:0] a;
    logic [1:0]  w;
    a = 15'h7fff;
    w = 2'h0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_index <= i;
    @(posedge clk);
    cmd_valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
      if (we_n === 1'b0) begin
        a = addr;
        w = {data_oe, data_out[0]};
      end
    end while (done !== 1'b1 && lat < 200);
    chk(done, 1'b1);
    if (c == cmd_take || c == cmd_release) begin
      chk(a, {12'h0, i});
      chk(w, {1'b1, (c == cmd_take) ? 1'b0 : 1'b1});
    end
  endtask
  // Right-hand processor access; strobes drop between accesses
  task automatic rport(input logic w, input logic b, input logic [2:0] i);
    @(posedge clk);
    r_sel_n <= 1'b0;
    r_we_n <= !w;
    r_oe_n <= w;
    r_idx <= i;
    r_din <= b;
    repeat (2) @(posedge clk);
    d = r_dout;
    r_sel_n <= 1'b1;
    r_we_n <= 1'b1;
    r_oe_n <= 1'b1;
  endtask
  initial begin
    #(40 * 20000);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({cmd_ready, done, granted, data_oe, sel_n, oe_n, we_n, mem_enable_n}, 16'h008f);
    // Frozen controller must not take a request
    @(posedge clk);
    ce <= 1'b0;
    cmd_valid <= 1'b1;
    cmd <= cmd_take;
    repeat (4) @(posedge clk);
    chk({cmd_ready, sel_n, we_n}, 16'h0007);
    cmd_valid <= 1'b0;
    ce <= 1'b1;
    run(cmd_init_all, 3'h0);
    for (int i = 0; i < 8; i++) rport(1'b1, 1'b1, i[2:0]);
    foreach (rows[k]) begin
      run(rows[k].c, rows[k].i);
      chk(granted, rows[k].g);
      if (rows[k].c == cmd_take) chk(lat, 16'(2 * `STROBE_CYCLES + 2 * `GAP_CYCLES + 6));
    end
    rport(1'b1, 1'b0, 3'h5);
    rport(1'b0, 1'b1, 3'h5);
    chk(d, 16'h0000);
    run(cmd_take, 3'h5);
    chk(granted, 1'b0);
    rport(1'b0, 1'b1, 3'h5);
    chk(d, 16'h0000);
    rport(1'b1, 1'b1, 3'h5);
    run(cmd_poll, 3'h5);
    chk(granted, 1'b1);
    rport(1'b0, 1'b1, 3'h5);
    chk(d, 16'h00ff);
    run(cmd_release, 3'h5);
    run(cmd_poll, 3'h5);
    chk(granted, 1'b0);
    run(cmd_take, 3'h6);
    chk(granted, 1'b1);
    // Right request pends, then a held read must not follow the hand-over
    rport(1'b1, 1'b0, 3'h6);
    @(posedge clk);
    r_sel_n <= 1'b0;
    r_oe_n <= 1'b0;
    r_idx <= 3'h6;
    run(cmd_release, 3'h6);
    chk(r_dout, 16'h00ff);
    r_sel_n <= 1'b1;
    r_oe_n <= 1'b1;
    rport(1'b0, 1'b1, 3'h6);
    chk(d, 16'h0000);
    stop_test();
  end
endmodule
